// ### metering_event_status_flags.sv
// Status flag register bank with three-byte register read port
module metering_event_status_flags
	import status_flags_pkg::*;
(
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Waveform signs, A voltage first: va ia vb ib vc ic in
	input wire logic [6:0] wave_sign,
	// Events from the metering core, one-cycle pulses
	input wire logic [2:0] voltage_dip,
	input wire logic [2:0] zx_timeout,
	input wire logic [2:0] volt_rms_peak_over,
	input wire logic [3:0] curr_rms_peak_over,
	// Phase sequence
	input wire logic volt_reversed,
	input wire logic curr_reversed,
	input wire logic curr_above_min,
	input wire logic phase_failed,
	// Power signs, 1 is negative
	input wire logic [2:0] watt_sign,
	input wire logic [2:0] var_sign,
	input wire logic [2:0] fvar_sign,
	input wire logic [2:0] fwatt_sign,
	input wire logic [2:0] va_sign,
	input wire logic total_watt_sign,
	input wire logic total_fwatt_sign,
	// Reference monitor and serial frame checks
	input wire logic vref_low_pin,
	input wire logic spi_frame_done,
	input wire logic spi_sum_bad,
	input wire logic uart_frame_done,
	input wire logic uart_sum_bad,
	// Interface select pin
	input wire logic sel_pin,
	// Register read port
	input wire logic rd_req,
	input wire logic [7:0] rd_addr,
	input wire logic rd_next,
	output logic [7:0] rd_byte,
	output logic rd_valid,
	output logic rd_hit,
	output logic spi_active
);
	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	logic [8:0] pin_meta;
	logic [8:0] pin_sync;
	logic [6:0] sign_s;
	logic vref_s;
	logic sel_s;

	always_ff @(posedge mclk)
	begin
		pin_meta <= {sel_pin, vref_low_pin, wave_sign};
		pin_sync <= pin_meta;
	end
	assign sign_s = pin_sync[6:0];
	assign vref_s = pin_sync[7];
	assign sel_s = pin_sync[8];

	// ----------------------------------------
	// Sign change detection
	// ----------------------------------------
	sign_change_if sc ();
	assign sc.watt = watt_sign;
	assign sc.var_q = var_sign;
	assign sc.fvar = fvar_sign;
	assign sc.fwatt = fwatt_sign;
	assign sc.va = va_sign;
	assign sc.total = {total_fwatt_sign, total_watt_sign};

	sign_change_detect u_detect (
		.mclk(mclk),
		.rst(rst),
		.sc(sc.detect)
	);

	// ----------------------------------------
	// Flag set terms
	// ----------------------------------------
	// Event flags latch; a read frame does not clear them because the host side is read-only
	logic [23:0] set_one;
	logic [23:0] set_two;
	logic [23:0] live_one;
	logic [23:0] live_two;
	logic [23:0] live_mask_one;
	logic [23:0] live_mask_two;
	logic any_fwatt;

	assign any_fwatt = (|sc.chg_watt) | (|sc.chg_fwatt);
	always_comb
	begin
		set_one = status_reset;
		set_one[s1_dip_lsb +: 3] = voltage_dip; // [RULE18]
		set_one[s1_zto_lsb +: 3] = zx_timeout;
		set_one[s1_peak_lsb] = volt_rms_peak_over[0]; // [RULE2]
		set_one[s1_peak_lsb + 2] = volt_rms_peak_over[1]; // [RULE2]
		set_one[s1_peak_lsb + 4] = volt_rms_peak_over[2]; // [RULE2]
		set_one[s1_peak_lsb + 1] = curr_rms_peak_over[0]; // [RULE3]
		set_one[s1_peak_lsb + 3] = curr_rms_peak_over[1]; // [RULE3]
		set_one[s1_peak_lsb + 5] = curr_rms_peak_over[2]; // [RULE3]
		set_one[s1_neutral_peak] = curr_rms_peak_over[3]; // [RULE3]
		set_two = status_reset;
		set_two[s2_watt_lsb +: 3] = sc.chg_watt; // [RULE6]
		set_two[s2_var_lsb +: 3] = sc.chg_var; // [RULE7]
		set_two[s2_fvar_lsb +: 3] = sc.chg_fvar; // [RULE8]
		set_two[s2_fwatt_lsb +: 3] = sc.chg_fwatt; // [RULE9]
		set_two[s2_va_lsb +: 3] = sc.chg_va; // [RULE10]
		set_two[s2_total_watt] = sc.chg_total[0]; // [RULE11]
		set_two[s2_total_fwatt] = sc.chg_total[1]; // [RULE11]
		set_two[s2_or_lsb] = any_fwatt; // [RULE12]
		set_two[s2_or_lsb + 1] = |sc.chg_var; // [RULE12]
		set_two[s2_or_lsb + 2] = |sc.chg_fvar; // [RULE12]
		set_two[s2_or_lsb + 3] = |sc.chg_va; // [RULE12]
	end

	// Live fields track their cause every cycle
	always_comb
	begin
		live_one = status_reset;
		live_mask_one = status_reset;
		live_one[s1_sign_lsb +: 7] = sign_s; // [RULE1] [RULE19]
		live_mask_one[s1_sign_lsb +: 7] = 7'h7f;
		live_one[s1_volt_order] = volt_reversed & ~phase_failed; // [RULE4]
		live_one[s1_curr_order] = curr_reversed & curr_above_min & ~phase_failed; // [RULE5]
		live_mask_one[s1_volt_order] = 1'b1;
		live_mask_one[s1_curr_order] = 1'b1;
		live_two = status_reset;
		live_mask_two = status_reset;
		live_two[s2_vref_low] = vref_s; // [RULE13]
		live_mask_two[s2_vref_low] = 1'b1;
	end

	// ----------------------------------------
	// Flag registers
	// ----------------------------------------
	logic [23:0] status_one;
	logic [23:0] status_two;
	logic [23:0] next_status_one;
	logic [23:0] next_status_two;
	logic next_spi_err;
	logic next_uart_err;

	// Checksum flags reflect the latest frame on each interface
	assign next_spi_err = spi_frame_done ? spi_sum_bad : status_two[s2_spi_err];
	assign next_uart_err = uart_frame_done ? uart_sum_bad : status_two[s2_uart_err];
	assign next_status_one = (live_one & live_mask_one)
		| ((status_one | set_one) & ~live_mask_one);
	always_comb
	begin
		next_status_two = (live_two & live_mask_two)
			| ((status_two | set_two) & ~live_mask_two);
		next_status_two[s2_spi_err] = next_spi_err; // [RULE14]
		next_status_two[s2_uart_err] = next_uart_err; // [RULE15]
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			status_one <= status_reset; // [RULE20]
			status_two <= status_reset; // [RULE20]
		end
		else
		begin
			status_one <= next_status_one;
			status_two <= next_status_two;
		end
	end

	// ----------------------------------------
	// Three-byte read port
	// ----------------------------------------
	function automatic logic [23:0] reg_select(input logic [7:0] a,
		input logic [23:0] one, input logic [23:0] two);
		if (a == event_status_one_addr)
			reg_select = one;
		else if (a == event_status_two_addr)
			reg_select = two;
		else
			reg_select = status_reset;
	endfunction : reg_select

	function automatic logic [7:0] byte_pick(input logic [23:0] w, input logic [1:0] i);
		byte_pick = w[(reg_width - 8) - 8 * i +: 8];
	endfunction : byte_pick

	logic [23:0] snap;
	logic [1:0] byte_idx;
	logic busy;
	logic addr_hit;
	logic [23:0] rd_word;

	assign rd_word = reg_select(rd_addr, status_one, status_two);
	assign addr_hit = (rd_addr == event_status_one_addr) | (rd_addr == event_status_two_addr);
	assign spi_active = sel_s; // [RULE17]

	// Snapshot on request so the three bytes belong to one word
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			snap <= status_reset;
			byte_idx <= 2'h0;
			busy <= 1'b0;
			rd_byte <= 8'h00;
			rd_valid <= 1'b0;
			rd_hit <= 1'b0;
		end
		else if (rd_req && !busy)
		begin
			snap <= rd_word; // [RULE16]
			byte_idx <= 2'h0;
			busy <= 1'b1;
			rd_byte <= byte_pick(rd_word, 2'h0); // [RULE16]
			rd_valid <= 1'b1;
			rd_hit <= addr_hit;
		end
		else if (busy && rd_next)
		begin
			if (byte_idx == byte_index_last)
			begin
				busy <= 1'b0;
				rd_valid <= 1'b0;
			end
			else
			begin
				byte_idx <= byte_idx + 2'h1;
				rd_byte <= byte_pick(snap, byte_idx + 2'h1); // [RULE16]
			end
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	a_reset_clears_flags: assert property (@(posedge mclk) rst |=> (status_one == status_reset)) // [RULE20]
		else $error("status one not zero after reset");
	a_volt_order_fail: assert property (@(posedge mclk) disable iff (rst) // [RULE4]
		phase_failed |=> !status_one[s1_volt_order])
		else $error("voltage order not forced low on phase failure");
	a_volt_order_live: assert property (@(posedge mclk) disable iff (rst) // [RULE4]
		(volt_reversed && !phase_failed) |=> status_one[s1_volt_order])
		else $error("voltage order reversal not shown");
	a_curr_order_fail: assert property (@(posedge mclk) disable iff (rst) // [RULE5]
		(phase_failed || !curr_above_min) |=> !status_one[s1_curr_order])
		else $error("current order not forced low");
	a_dip_latches: assert property (@(posedge mclk) disable iff (rst) // [RULE18]
		voltage_dip[0] |=> status_one[s1_dip_lsb] [*3])
		else $error("dip flag not latched");
	a_dip_phase_c: assert property (@(posedge mclk) disable iff (rst) // [RULE18]
		voltage_dip[2] |=> status_one[s1_dip_lsb + 2])
		else $error("phase c dip flag not set");
	a_neutral_peak: assert property (@(posedge mclk) disable iff (rst) // [RULE3]
		curr_rms_peak_over[3] |=> status_one[s1_neutral_peak])
		else $error("neutral peak flag not set");
	a_curr_peak_c: assert property (@(posedge mclk) disable iff (rst) // [RULE3]
		curr_rms_peak_over[2] |=> status_one[s1_peak_lsb + 5])
		else $error("phase c current peak flag not set");
	a_volt_peak_a: assert property (@(posedge mclk) disable iff (rst) // [RULE2]
		volt_rms_peak_over[0] |=> status_one[s1_peak_lsb])
		else $error("voltage peak flag not set");
	a_sign_tracks: assert property (@(posedge mclk) disable iff (rst) // [RULE1] [RULE19]
		status_one[s1_sign_lsb +: 7] == $past(sign_s))
		else $error("sign bits do not track waveform");
	a_watt_change: assert property (@(posedge mclk) disable iff (rst) // [RULE6] [RULE12]
		sc.chg_watt[0] |=> status_two[s2_watt_lsb] && status_two[s2_or_lsb])
		else $error("active sign change not flagged");
	a_var_change: assert property (@(posedge mclk) disable iff (rst) // [RULE7] [RULE12]
		sc.chg_var[1] |=> status_two[s2_var_lsb + 1] && status_two[s2_or_lsb + 1])
		else $error("reactive sign change not flagged");
	a_fvar_change: assert property (@(posedge mclk) disable iff (rst) // [RULE8] [RULE12]
		sc.chg_fvar[2] |=> status_two[s2_fvar_lsb + 2] && status_two[s2_or_lsb + 2])
		else $error("fundamental reactive sign change not flagged");
	a_fwatt_change: assert property (@(posedge mclk) disable iff (rst) // [RULE9] [RULE12]
		sc.chg_fwatt[0] |=> status_two[s2_fwatt_lsb] && status_two[s2_or_lsb])
		else $error("fundamental active sign change not flagged");
	a_va_change: assert property (@(posedge mclk) disable iff (rst) // [RULE10] [RULE12]
		sc.chg_va[1] |=> status_two[s2_va_lsb + 1] && status_two[s2_or_lsb + 3])
		else $error("apparent sign change not flagged");
	a_total_change: assert property (@(posedge mclk) disable iff (rst) // [RULE11]
		sc.chg_total[0] |=> status_two[s2_total_watt])
		else $error("total active sign change not flagged");
	a_vref_tracks: assert property (@(posedge mclk) disable iff (rst) // [RULE13]
		status_two[s2_vref_low] == $past(vref_s))
		else $error("low reference flag does not track");
	a_spi_sum_err: assert property (@(posedge mclk) disable iff (rst) // [RULE14]
		spi_frame_done |=> status_two[s2_spi_err] == $past(spi_sum_bad))
		else $error("spi checksum flag wrong");
	a_uart_sum_err: assert property (@(posedge mclk) disable iff (rst) // [RULE15]
		uart_frame_done |=> status_two[s2_uart_err] == $past(uart_sum_bad))
		else $error("uart checksum flag wrong");
	a_three_bytes: assert property (@(posedge mclk) disable iff (rst) // [RULE16]
		(rd_req && !busy) ##1 rd_next [*3] |=> !rd_valid)
		else $error("read did not end after three bytes");
	a_first_byte: assert property (@(posedge mclk) disable iff (rst) // [RULE16]
		(rd_req && !busy && (rd_addr == event_status_two_addr))
		|=> rd_valid && rd_hit && (rd_byte == $past(status_two[reg_width - 1 -: 8])))
		else $error("first byte of read wrong");
	a_unmapped_zero: assert property (@(posedge mclk) disable iff (rst) // [RULE16]
		(rd_req && !busy && !addr_hit) |=> (rd_byte == 8'h00) && !rd_hit)
		else $error("unmapped read not zero");

	c_dip_seen: cover property (@(posedge mclk) disable iff (rst) voltage_dip[0]);
	c_read_done: cover property (@(posedge mclk) disable iff (rst) busy ##1 !busy);
	c_spi_err: cover property (@(posedge mclk) disable iff (rst) spi_frame_done && spi_sum_bad);
	c_total_change: cover property (@(posedge mclk) disable iff (rst) |sc.chg_total);
	c_order_reversed: cover property (@(posedge mclk) disable iff (rst) status_one[s1_volt_order]);
endmodule : metering_event_status_flags

// ### metering_event_status_flags_tb_top.sv
// Self-checking testbench for the event status flag registers
module metering_event_status_flags_tb_top
	import status_flags_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic [6:0] wave_sign = 7'h00;
	logic [2:0] voltage_dip = 3'h0;
	logic [2:0] zx_timeout = 3'h0;
	logic [2:0] volt_pk = 3'h0;
	logic [3:0] curr_pk = 4'h0;
	// Volt reversed, curr reversed, curr above min, phase failed
	logic [3:0] order_in = 4'h0;
	logic [14:0] psign = 15'h0000;
	logic [1:0] tsign = 2'h0;
	// Vref low, spi done, spi bad, uart done, uart bad
	logic [4:0] misc_in = 5'h00;
	logic sel_pin = 1'b0;
	logic rd_req;
	logic rd_next;
	logic rd_valid;
	logic rd_hit;
	logic spi_active;
	logic [7:0] rd_addr;
	logic [7:0] rd_byte;
	int fails = 0;
	int comparisons = 0;
	int sum_pos [5] = '{17, 18, 19, 17, 20};

	always #10 mclk = ~mclk;

	metering_event_status_flags i_dut (.mclk(mclk), .rst(rst), .wave_sign(wave_sign),
		.voltage_dip(voltage_dip), .zx_timeout(zx_timeout), .volt_rms_peak_over(volt_pk),
		.curr_rms_peak_over(curr_pk), .volt_reversed(order_in[3]), .curr_reversed(order_in[2]),
		.curr_above_min(order_in[1]), .phase_failed(order_in[0]), .watt_sign(psign[2:0]),
		.var_sign(psign[5:3]), .fvar_sign(psign[8:6]), .fwatt_sign(psign[11:9]),
		.va_sign(psign[14:12]), .total_watt_sign(tsign[0]), .total_fwatt_sign(tsign[1]),
		.vref_low_pin(misc_in[4]), .spi_frame_done(misc_in[3]), .spi_sum_bad(misc_in[2]),
		.uart_frame_done(misc_in[1]), .uart_sum_bad(misc_in[0]), .sel_pin(sel_pin),
		.rd_req(rd_req), .rd_addr(rd_addr), .rd_next(rd_next), .rd_byte(rd_byte),
		.rd_valid(rd_valid), .rd_hit(rd_hit), .spi_active(spi_active));

	metering_host_model i_host (.mclk(mclk), .rd_req(rd_req), .rd_addr(rd_addr),
		.rd_next(rd_next), .rd_byte(rd_byte), .rd_valid(rd_valid), .rd_hit(rd_hit));

	// ----
	// Shared helpers
	// ----
	task automatic check(input logic [23:0] got, input logic [23:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			fails++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask : check

	task automatic expect_reg(input logic [7:0] addr, input logic [23:0] exp, input int gap);
		logic [23:0] data;
		logic hit;
		logic ok;
		i_host.read_reg(addr, gap, data, hit, ok);
		check(data, exp);
		check({22'h0, hit, ok},
			{22'h0, addr == event_status_one_addr || addr == event_status_two_addr, 1'b1});
	endtask : expect_reg

	task automatic do_reset();
		@(posedge mclk);
		rst <= 1'b1;
		{wave_sign, psign, tsign, order_in, misc_in} <= '0;
		repeat (10) @(posedge mclk);
		rst <= 1'b0;
	endtask : do_reset

	task automatic tally_and_finish();
		if (fails == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : tally_and_finish

	// ----
	// Scenarios
	// ----
	task automatic sc_reset();
		do_reset();
		expect_reg(event_status_one_addr, 24'h000000, 0);
		expect_reg(event_status_two_addr, 24'h000000, 2);
		expect_reg(8'h56, 24'h000000, 0);
	endtask : sc_reset

	task automatic sc_signs();
		do_reset();
		@(posedge mclk) wave_sign <= 7'h5a;
		repeat (4) @(posedge mclk);
		expect_reg(event_status_one_addr, 24'h001680, 0);
		@(posedge mclk) wave_sign <= 7'h25;
		repeat (4) @(posedge mclk);
		expect_reg(event_status_one_addr, 24'h000940, 1);
	endtask : sc_signs

	task automatic sc_events();
		do_reset();
		@(posedge mclk) {voltage_dip, zx_timeout, volt_pk, curr_pk} <= {3'h5, 3'h2, 3'h5, 4'h9};
		@(posedge mclk) {voltage_dip, zx_timeout, volt_pk, curr_pk} <= {3'h0, 3'h0, 3'h2, 4'h6};
		@(posedge mclk) {voltage_dip, zx_timeout, volt_pk, curr_pk} <= '0;
		expect_reg(event_status_one_addr, 24'h0fe015, 1);
	endtask : sc_events

	task automatic sc_order();
		do_reset();
		@(posedge mclk) order_in <= 4'he;
		repeat (2) @(posedge mclk);
		expect_reg(event_status_one_addr, 24'h600000, 0);
		@(posedge mclk) order_in <= 4'hc;
		repeat (2) @(posedge mclk);
		expect_reg(event_status_one_addr, 24'h200000, 0);
		@(posedge mclk) order_in <= 4'hf;
		repeat (2) @(posedge mclk);
		expect_reg(event_status_one_addr, 24'h000000, 0);
	endtask : sc_order

	task automatic sc_power();
		for (int g = 0; g < 5; g++)
		begin
			do_reset();
			@(posedge mclk) psign <= 15'h0001 << (3 * g + g % 3);
			repeat (2) @(posedge mclk);
			// Groups cycle through phases A, B, C in turn so a swapped index shows
			expect_reg(event_status_two_addr,
				(24'h1 << (3 * g + g % 3)) | (24'h1 << sum_pos[g]), g);
		end
		do_reset();
		@(posedge mclk) tsign <= 2'h3;
		repeat (2) @(posedge mclk);
		expect_reg(event_status_two_addr, 24'h018000, 0);
	endtask : sc_power

	task automatic sc_misc();
		do_reset();
		@(posedge mclk) misc_in <= 5'h1f;
		@(posedge mclk) misc_in <= 5'h10;
		repeat (3) @(posedge mclk);
		expect_reg(event_status_two_addr, 24'he00000, 0);
		@(posedge mclk) misc_in <= 5'h08;
		@(posedge mclk) misc_in <= 5'h00;
		repeat (3) @(posedge mclk);
		expect_reg(event_status_two_addr, 24'h800000, 0);
		@(posedge mclk) sel_pin <= 1'b1;
		repeat (4) @(negedge mclk);
		check({23'h0, spi_active}, 24'h000001);
		@(posedge mclk) sel_pin <= 1'b0;
		repeat (4) @(negedge mclk);
		check({23'h0, spi_active}, 24'h000000);
	endtask : sc_misc

	// ----
	// Main sequence and hang guard
	// ----
	initial
	begin
		sc_reset();
		sc_signs();
		sc_events();
		sc_order();
		sc_power();
		sc_misc();
		tally_and_finish();
	end

	initial
	begin
		#400000;
		fails++;
		tally_and_finish();
	end
endmodule : metering_event_status_flags_tb_top

// ### metering_host_model.sv
// Host model reading the status registers three bytes at a time
module metering_host_model
(
	// Clock
	input wire logic mclk,
	// Register read port
	output logic rd_req,
	output logic [7:0] rd_addr,
	output logic rd_next,
	input wire logic [7:0] rd_byte,
	input wire logic rd_valid,
	input wire logic rd_hit
);
	timeunit 1ns;
	timeprecision 1ps;

	initial
	begin
		rd_req = 1'b0;
		rd_addr = 8'h00;
		rd_next = 1'b0;
	end

	// ----
	// One register read, gap idles before each advance
	// ----
	task automatic read_reg(input logic [7:0] addr, input int gap, output logic [23:0] data,
		output logic hit, output logic ok);
		@(posedge mclk);
		rd_req <= 1'b1;
		rd_addr <= addr;
		@(posedge mclk);
		rd_req <= 1'b0;
		// Address unqualified now, so it must not look valid
		rd_addr <= ~addr;
		// No gap streams the three advances back to back
		rd_next <= (gap == 0);
		@(negedge mclk);
		hit = rd_hit;
		ok = rd_valid;
		data[23:16] = rd_byte;
		for (int i = 1; i < 4; i++)
		begin
			if (gap > 0)
			begin
				repeat (gap) @(posedge mclk);
				rd_next <= 1'b1;
			end
			@(posedge mclk);
			if (gap > 0 || i == 3)
				rd_next <= 1'b0;
			@(negedge mclk);
			if (i < 3)
			begin
				data[23 - 8 * i -: 8] = rd_byte;
				ok = ok & rd_valid;
			end
			else
				ok = ok & !rd_valid;
		end
	endtask : read_reg
endmodule : metering_host_model

// ### sign_change_detect.sv
// Edge detector turning power signs into one-cycle change pulses
module sign_change_detect
	import status_flags_pkg::*;
(
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Signs in, change pulses out
	sign_change_if.detect sc
);
	logic [16:0] last;
	logic [16:0] now;
	logic primed;
	logic [16:0] diff;

	assign now = {sc.total, sc.va, sc.fwatt, sc.fvar, sc.var_q, sc.watt};
	// First sample after reset is not a change
	assign diff = primed ? (now ^ last) : 17'h00000;
	assign sc.chg_watt = diff[2:0];
	assign sc.chg_var = diff[5:3];
	assign sc.chg_fvar = diff[8:6];
	assign sc.chg_fwatt = diff[11:9];
	assign sc.chg_va = diff[14:12];
	assign sc.chg_total = diff[16:15];

	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			last <= 17'h00000;
			primed <= 1'b0;
		end
		else
		begin
			last <= now;
			primed <= 1'b1;
		end
	end
endmodule : sign_change_detect

// ### sign_change_if.sv
// Interface carrying per-phase power signs into the change detector
interface sign_change_if;
	logic [2:0] watt;
	logic [2:0] var_q;
	logic [2:0] fvar;
	logic [2:0] fwatt;
	logic [2:0] va;
	logic [1:0] total;
	logic [2:0] chg_watt;
	logic [2:0] chg_var;
	logic [2:0] chg_fvar;
	logic [2:0] chg_fwatt;
	logic [2:0] chg_va;
	logic [1:0] chg_total;
	modport source (output watt, var_q, fvar, fwatt, va, total,
		input chg_watt, chg_var, chg_fvar, chg_fwatt, chg_va, chg_total);
	modport detect (input watt, var_q, fvar, fwatt, va, total,
		output chg_watt, chg_var, chg_fvar, chg_fwatt, chg_va, chg_total);
endinterface : sign_change_if

// ### status_flags_pkg.sv
// Constants for the metering event status flag registers
// Contract
// [RULE1] Status one bits 7..12 show live signs of IA, VB, IB, VC, IC, IN.
// [RULE2] Voltage peak flags set when RMS peak exceeds voltage peak threshold.
// [RULE3] Current peak flags set above current threshold; neutral flag is bit 19.
// [RULE4] Bit 21 voltage order, 1 reversed, forced 0 on phase failure.
// [RULE5] Bit 22 current order, valid above 5%Ib, forced 0 on phase failure.
// [RULE6] Status two bits 0..2 flag active power sign change, phases A..C.
// [RULE7] Bits 3..5 flag reactive power sign change, phases A..C.
// [RULE8] Bits 6..8 flag fundamental reactive sign change, phases A..C.
// [RULE9] Bits 9..11 flag fundamental active sign change, phases A..C.
// [RULE10] Bits 12..14 flag apparent power sign change, phases A..C.
// [RULE11] Bits 15 and 16 flag total active and total fundamental active sign change.
// [RULE12] Bits 17..20 summarise any-phase sign change per quantity group.
// [RULE13] Bit 21 low-reference flag follows reference below one volt.
// [RULE14] Bit 22 set on SPI frame checksum error, else zero.
// [RULE15] Bit 23 set on UART frame checksum error, else zero.
// [RULE16] Registers travel as three bytes, unused upper bits zero-filled.
// [RULE17] Interface select pin high picks SPI, low picks UART.
// [RULE18] Status one bits 0..2 set on voltage dip of phases A..C.
// [RULE19] Status one bit 6 shows live sign of phase A voltage.
// [RULE20] All flags zero after reset and read-only to the host.
package status_flags_pkg;
	localparam int reg_width = 24;
	localparam logic [7:0] event_status_one_addr = 8'h54;
	localparam logic [7:0] event_status_two_addr = 8'h55;
	localparam logic [23:0] status_reset = 24'h000000;
	// Status one fields
	localparam int s1_dip_lsb = 0;
	localparam int s1_zto_lsb = 3;
	localparam int s1_sign_lsb = 6;
	localparam int s1_peak_lsb = 13;
	localparam int s1_neutral_peak = 19;
	localparam int s1_volt_order = 21;
	localparam int s1_curr_order = 22;
	// Status two fields
	localparam int s2_watt_lsb = 0;
	localparam int s2_var_lsb = 3;
	localparam int s2_fvar_lsb = 6;
	localparam int s2_fwatt_lsb = 9;
	localparam int s2_va_lsb = 12;
	localparam int s2_total_watt = 15;
	localparam int s2_total_fwatt = 16;
	localparam int s2_or_lsb = 17;
	localparam int s2_vref_low = 21;
	localparam int s2_spi_err = 22;
	localparam int s2_uart_err = 23;
	localparam int power_groups = 5;
	localparam int bytes_per_reg = 3;
	localparam logic [1:0] byte_index_last = 2'h2;
endpackage : status_flags_pkg
